/* File: hdl/bmpg_pkg.sv */
package bmpg_pkg;

  // System clock
  localparam int CLK_HZ  = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // Sequencing times, microseconds then cycles
  localparam int SOFT_US     = 2500;
  localparam int SOFT_CYC    = SOFT_US * CLK_MHZ;
  localparam int HICCUP_US   = 25000;
  localparam int HICCUP_CYC  = HICCUP_US * CLK_MHZ;
  localparam int PG_RISE_US  = 100;
  localparam int PG_FALL_US  = 50;
  localparam logic [15:0] PG_RISE_CYC = 16'(PG_RISE_US * CLK_MHZ);
  localparam logic [15:0] PG_FALL_CYC = 16'(PG_FALL_US * CLK_MHZ);
  localparam int REF_STEPS   = 256;

  // Spread-spectrum triangle periods
  localparam int SSP_400K_US  = 1250;
  localparam int SSP_2M1_US   = 200;
  localparam int SSP_400K_CYC = SSP_400K_US * CLK_MHZ;
  localparam int SSP_2M1_CYC  = SSP_2M1_US * CLK_MHZ;
  localparam int SS_DEV_PCT   = 6;
  localparam int DUTY_MAX_PCT = 99;
  localparam int PCT_FULL     = 100;

  // Frequency options and their periods in system cycles
  localparam int FSW_400K_HZ = 400_000;
  localparam int FSW_2M1_HZ  = 2_100_000;
  localparam int FSW_3M_HZ   = 3_000_000;
  localparam logic [7:0] PER_400K = 8'(CLK_HZ / FSW_400K_HZ);
  localparam logic [7:0] PER_2M1  = 8'(CLK_HZ / FSW_2M1_HZ);
  localparam logic [7:0] PER_3M   = 8'(CLK_HZ / FSW_3M_HZ);
  localparam logic [1:0] FSEL_400K = 2'h0;
  localparam logic [1:0] FSEL_2M1  = 2'h1;
  localparam logic [1:0] FSEL_3M   = 2'h2;

  // Mode-pin clock detection
  localparam logic [7:0] SYNC_GAP_MAX = 8'hc8;
  localparam logic [1:0] SYNC_EDGES_LOCK = 2'h2;

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_STATE  = 8'h08;

  // Event bits of status and mask
  localparam int EV_LOCK  = 0;
  localparam int EV_LOST  = 1;
  localparam int EV_HIC   = 2;
  localparam int EV_PGF   = 3;
  localparam int EV_SOFT  = 4;
  localparam int EV_W     = 5;

  // State register fields
  localparam int ST_FSM_LSB  = 0;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_PG_BIT   = 6;
  localparam int ST_SS_BIT   = 7;
  localparam int ST_PIN_BIT  = 8;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_BIAS   = 3'h1,
    ST_SOFT   = 3'h3,
    ST_RUN    = 3'h2,
    ST_HICCUP = 3'h6
  } bmpg_state_t;

  typedef enum logic [1:0] {
    MD_SKIP = 2'h0,
    MD_FORCED_FIXED_FREQUENCY_MODE = 2'h1,
    MD_SYNC = 2'h2
  } bmpg_mode_t;

  // Longest high-side time for a given period, rounded down
  function automatic logic [7:0] duty_max(input logic [7:0] per);
    logic [15:0] p;
    p = 16'(per) * 16'(DUTY_MAX_PCT) / 16'(PCT_FULL);
    return p[7:0];
  endfunction

endpackage

/* File: hdl/bmpg_sync2.sv */
`timescale 1ns/1ps
module bmpg_sync2 #(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  // Two stages; the first feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule

/* File: hdl/bmpg_osc.sv */
`timescale 1ns/1ps
module bmpg_osc
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Fixed period and spread settings
  input  wire logic        ss_en,
  input  wire logic [7:0]  per,
  input  wire logic [2:0]  dev,
  input  wire logic [15:0] step_cyc,
  // One-cycle switching tick
  output logic             tick_q
);
  logic [7:0]  cnt_q;
  logic [3:0]  idx_q;
  logic        up_q;
  logic [15:0] stp_q;
  logic [7:0]  len;

  // Period swings from per-dev to per+dev; idx at dev is the centre
  assign len = per - 8'(dev) + 8'(idx_q);

  // Period counter; >= copes with a period shortening mid-count
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= len - 8'h01)
    begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // Triangle walk of the period offset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      idx_q <= 4'h0;
      up_q  <= 1'b1;
      stp_q <= 16'h0000;
    end
    else if (!ss_en || dev == 3'h0)
    begin
      idx_q <= 4'(dev);
      up_q  <= 1'b1;
      stp_q <= 16'h0000;
    end
    else if (stp_q >= step_cyc - 16'h0001)
    begin
      stp_q <= 16'h0000;
      if (up_q && idx_q >= {dev, 1'b0})
      begin
        up_q  <= 1'b0;
        idx_q <= idx_q - 4'h1;
      end
      else if (!up_q && idx_q == 4'h0)
      begin
        up_q  <= 1'b1;
        idx_q <= idx_q + 4'h1;
      end
      else
      begin
        idx_q <= up_q ? idx_q + 4'h1 : idx_q - 4'h1;
      end
    end
    else
    begin
      stp_q <= stp_q + 16'h0001;
    end
  end
endmodule

/* File: hdl/bmpg_top.sv */
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module bmpg_top #(
  parameter logic [1:0] FSW_SEL    = bmpg_pkg::FSEL_400K,
  parameter bit         INT_FB     = 1'b1,
  parameter int         SOFT_CYC   = bmpg_pkg::SOFT_CYC,
  parameter int         HICCUP_CYC = bmpg_pkg::HICCUP_CYC,
  parameter int         SS_TRI_CYC = (FSW_SEL == bmpg_pkg::FSEL_400K) ?
                                     bmpg_pkg::SSP_400K_CYC : bmpg_pkg::SSP_2M1_CYC
)
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ,
  // Control pins
  input  wire logic        EN,
  input  wire logic        MODE_CLK,
  input  wire logic        SPREAD_ENABLE_INPUT,
  // Analog status, asynchronous
  input  wire logic        RAIL_OK,
  input  wire logic        VOUT_UV,
  input  wire logic        VOUT_OV,
  input  wire logic        ILIM,
  input  wire logic        VOUT_HALF,
  input  wire logic        ON_END,
  input  wire logic        LIGHT_LOAD,
  input  wire logic        ZERO_CROSS,
  // Power stage and rail control
  output logic             BIAS_EN,
  output logic             BIAS_FROM_OUT,
  output logic             CONV_EN,
  output logic             HS_ON,
  output logic             LS_ON,
  output logic      [7:0]  SS_REF,
  // Open-drain output-ok pin
  input  wire logic        OUTPUT_OK_FLAG_I,
  output logic             OUTPUT_OK_FLAG_O,
  output logic             OUTPUT_OK_FLAG_OE
);
  localparam logic [7:0] INT_PER = (FSW_SEL == bmpg_pkg::FSEL_2M1) ? bmpg_pkg::PER_2M1 :
                                   (FSW_SEL == bmpg_pkg::FSEL_3M) ? bmpg_pkg::PER_3M :
                                   bmpg_pkg::PER_400K;
  localparam int DEV_I = int'(INT_PER) * bmpg_pkg::SS_DEV_PCT / bmpg_pkg::PCT_FULL;
  localparam logic [2:0] INT_DEV = 3'(DEV_I);
  localparam int STEP_I = SS_TRI_CYC / (4 * ((DEV_I == 0) ? 1 : DEV_I));
  localparam logic [15:0] STEP_CYC = 16'((STEP_I == 0) ? 1 : STEP_I);
  localparam int REF_I = SOFT_CYC / bmpg_pkg::REF_STEPS;
  localparam logic [15:0] REF_STEP = 16'((REF_I == 0) ? 1 : REF_I);
  localparam logic [18:0] SOFT_END = 19'(SOFT_CYC - 1);
  localparam logic [18:0] HIC_END  = 19'(HICCUP_CYC - 1);

  logic [11:0]               raw;
  logic [11:0]               syn;
  logic                      en_s, clk_s, sps_s, rail_s, uv_s, ov_s;
  logic                      ilim_s, half_s, onend_s, light_s, zc_s, okpin_s;
  logic                      clk_d_q, edge_c, lost;
  logic [7:0]                gap_q, per_q, max_on, on_cnt_q, cap_q;
  logic [1:0]                edges_q;
  logic                      lock_q, ss_en, osc_tick, sw_tick, run_sw;
  bmpg_pkg::bmpg_mode_t      mode_q;
  bmpg_pkg::bmpg_state_t     st_q;
  logic [18:0]               tmr_q;
  logic                      short_c, hs_q, ls_q;
  logic [15:0]               ps_q, db_q, db_lim;
  logic [7:0]                ref_q;
  logic                      pg_q, bad;
  logic [bmpg_pkg::EV_W-1:0] ev, clr, status_q, mask_q;
  logic [8:0]                state_word;
  logic [31:0]               rdata_q;

  // Every pin and comparator crosses two flops first
  assign raw = {OUTPUT_OK_FLAG_I, ZERO_CROSS, LIGHT_LOAD, ON_END, VOUT_HALF, ILIM,
                VOUT_OV, VOUT_UV, RAIL_OK, SPREAD_ENABLE_INPUT, MODE_CLK, EN};

  bmpg_sync2 #(.W(12)) u_sync (
    .clk    (CLK_SYS),
    .nrst   (NRST),
    .d      (raw),
    .sync_q (syn)
  );

  assign {okpin_s, zc_s, light_s, onend_s, half_s, ilim_s,
          ov_s, uv_s, rail_s, sps_s, clk_s, en_s} = syn;

  // Rising edges of the mode pin, found after synchronising
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      clk_d_q <= 1'b0;
    else
      clk_d_q <= clk_s;
  end

  assign edge_c = clk_s & ~clk_d_q;
  // Lost when the gap passes two measured periods or the cap
  assign lost = lock_q & ~edge_c &
                (({1'b0, gap_q} > {per_q, 1'b0}) | (gap_q == bmpg_pkg::SYNC_GAP_MAX));

  // Edge counting tells a clock from a static level
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      gap_q   <= 8'h00;
      per_q   <= 8'h00;
      edges_q <= 2'h0;
      lock_q  <= 1'b0;
    end
    else if (edge_c)
    begin
      gap_q <= 8'h00;
      per_q <= gap_q + 8'h01;
      if (edges_q != bmpg_pkg::SYNC_EDGES_LOCK)
        edges_q <= edges_q + 2'h1;
      if (edges_q != 2'h0)
        lock_q <= 1'b1;
    end
    else
    begin
      if (gap_q != bmpg_pkg::SYNC_GAP_MAX)
        gap_q <= gap_q + 8'h01;
      if (lost)
      begin
        lock_q  <= 1'b0;
        edges_q <= 2'h0;
      end
      else if (!lock_q && gap_q == bmpg_pkg::SYNC_GAP_MAX)
        edges_q <= 2'h0;
    end
  end

  // Mode follows the level while no edges are pending; the locking edge moves it at once
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      mode_q <= bmpg_pkg::MD_SKIP;
    else if (lock_q || (edge_c && edges_q != 2'h0))
      mode_q <= bmpg_pkg::MD_SYNC;
    else if (edges_q == 2'h0)
      mode_q <= clk_s ? bmpg_pkg::MD_FORCED_FIXED_FREQUENCY_MODE : bmpg_pkg::MD_SKIP;
  end

  // Spreading only on the internal oscillator
  assign ss_en = sps_s & ~lock_q;

  bmpg_osc u_osc (
    .clk      (CLK_SYS),
    .nrst     (NRST),
    .ss_en    (ss_en),
    .per      (INT_PER),
    .dev      (INT_DEV),
    .step_cyc (STEP_CYC),
    .tick_q   (osc_tick)
  );

  // Locked: switch on the external rising edge, else internal tick
  assign sw_tick = lock_q ? edge_c : osc_tick;
  // Spreading caps on its shortest period, trading a little dropout duty for safety
  assign max_on  = bmpg_pkg::duty_max(lock_q ? per_q :
                                      ss_en ? INT_PER - 8'(INT_DEV) : INT_PER);
  assign short_c = ilim_s & half_s;

  // Start-up, shutdown and hiccup sequence
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      st_q  <= bmpg_pkg::ST_OFF;
      tmr_q <= 19'h00000;
    end
    else if (!en_s)
    begin
      st_q  <= bmpg_pkg::ST_OFF;
      tmr_q <= 19'h00000;
    end
    else
    begin
      case (st_q)
        bmpg_pkg::ST_OFF:
          st_q <= bmpg_pkg::ST_BIAS;
        bmpg_pkg::ST_BIAS:
          if (rail_s)
          begin
            st_q  <= bmpg_pkg::ST_SOFT;
            tmr_q <= 19'h00000;
          end
        bmpg_pkg::ST_SOFT:
          if (tmr_q == SOFT_END)
            st_q <= bmpg_pkg::ST_RUN;
          else
            tmr_q <= tmr_q + 19'h00001;
        bmpg_pkg::ST_RUN:
          if (short_c)
          begin
            st_q  <= bmpg_pkg::ST_HICCUP;
            tmr_q <= 19'h00000;
          end
        bmpg_pkg::ST_HICCUP:
          if (tmr_q == HIC_END)
          begin
            st_q  <= bmpg_pkg::ST_SOFT;
            tmr_q <= 19'h00000;
          end
          else
            tmr_q <= tmr_q + 19'h00001;
        default:
          st_q <= bmpg_pkg::ST_OFF;
      endcase
    end
  end

  assign BIAS_EN       = (st_q != bmpg_pkg::ST_OFF);
  assign run_sw        = (st_q == bmpg_pkg::ST_SOFT) | (st_q == bmpg_pkg::ST_RUN);
  assign CONV_EN       = run_sw;
  assign BIAS_FROM_OUT = INT_FB & (st_q == bmpg_pkg::ST_RUN);

  // Soft-start reference climbs one step per REF_STEP cycles
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      ps_q  <= 16'h0000;
      ref_q <= 8'h00;
    end
    else if (st_q == bmpg_pkg::ST_RUN)
    begin
      ps_q  <= 16'h0000;
      ref_q <= 8'hff;
    end
    else if (st_q != bmpg_pkg::ST_SOFT)
    begin
      ps_q  <= 16'h0000;
      ref_q <= 8'h00;
    end
    else if (ps_q == REF_STEP - 16'h0001)
    begin
      ps_q <= 16'h0000;
      if (ref_q != 8'hff)
        ref_q <= ref_q + 8'h01;
    end
    else
      ps_q <= ps_q + 16'h0001;
  end

  assign SS_REF = ref_q;

  // Gate drive; cap latched per pulse so a mode change mid-pulse cannot undercut it
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST || !run_sw)
    begin
      hs_q     <= 1'b0;
      ls_q     <= 1'b0;
      on_cnt_q <= 8'h00;
      cap_q    <= 8'h00;
    end
    else if (sw_tick && !(mode_q == bmpg_pkg::MD_SKIP && light_s))
    begin
      hs_q     <= 1'b1;
      ls_q     <= 1'b0;
      on_cnt_q <= 8'h00;
      cap_q    <= max_on;
    end
    else if (hs_q)
    begin
      on_cnt_q <= on_cnt_q + 8'h01;
      if (onend_s || on_cnt_q + 8'h01 >= cap_q)
      begin
        hs_q <= 1'b0;
        ls_q <= 1'b1;
      end
    end
    else if (ls_q && mode_q == bmpg_pkg::MD_SKIP && zc_s)
      ls_q <= 1'b0;
  end

  assign HS_ON = hs_q;
  assign LS_ON = ls_q;

  // Output window with debounce; shutdown pulls low at once
  assign bad    = uv_s | ov_s | (st_q != bmpg_pkg::ST_RUN);
  assign db_lim = pg_q ? bmpg_pkg::PG_FALL_CYC - 16'h0001 : bmpg_pkg::PG_RISE_CYC - 16'h0001;

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST || st_q == bmpg_pkg::ST_OFF)
    begin
      pg_q <= 1'b0;
      db_q <= 16'h0000;
    end
    else if (bad == pg_q)
    begin
      if (db_q == db_lim)
      begin
        pg_q <= ~pg_q;
        db_q <= 16'h0000;
      end
      else
        db_q <= db_q + 16'h0001;
    end
    else
      db_q <= 16'h0000;
  end

  assign OUTPUT_OK_FLAG_O  = 1'b0;
  assign OUTPUT_OK_FLAG_OE = ~pg_q;

  // Sticky events; a set in the clearing cycle wins
  assign ev[bmpg_pkg::EV_LOCK] = edge_c & ~lock_q & (edges_q != 2'h0);
  assign ev[bmpg_pkg::EV_LOST] = lost;
  assign ev[bmpg_pkg::EV_HIC]  = en_s & (st_q == bmpg_pkg::ST_RUN) & short_c;
  assign ev[bmpg_pkg::EV_PGF]  = pg_q & bad & (db_q == db_lim);
  assign ev[bmpg_pkg::EV_SOFT] = en_s & (st_q == bmpg_pkg::ST_SOFT) & (tmr_q == SOFT_END);
  assign clr = (WR && ADDR == bmpg_pkg::REG_STATUS) ? WDATA[bmpg_pkg::EV_W-1:0] : '0;

  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      status_q <= '0;
    else
      status_q <= (status_q & ~clr) | ev;
  end

  // Mask register steers the interrupt line
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST)
      mask_q <= '0;
    else if (WR && ADDR == bmpg_pkg::REG_MASK)
      mask_q <= WDATA[bmpg_pkg::EV_W-1:0];
  end

  assign IRQ = |(status_q & mask_q);
  // Fields from bit 0: state, lock, mode, ok flag, spread, pin level
  assign state_word = {okpin_s, ss_en, pg_q, mode_q, lock_q, st_q};

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS)
  begin
    if (!NRST || !RD)
      rdata_q <= 32'h00000000;
    else if (ADDR == bmpg_pkg::REG_STATUS)
      rdata_q <= 32'(status_q);
    else if (ADDR == bmpg_pkg::REG_MASK)
      rdata_q <= 32'(mask_q);
    else if (ADDR == bmpg_pkg::REG_STATE)
      rdata_q <= 32'(state_word);
    else
      rdata_q <= 32'h00000000;
  end

  assign RDATA = rdata_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_skip_level: assert property (mode_q == bmpg_pkg::MD_SKIP |-> !lock_q)
    else $error("skip mode while locked");
  a_lock_two: assert property (edge_c && edges_q == 2'h1 |=> lock_q)
    else $error("no lock on second edge");
  a_lost_revert: assert property (lost |=> !lock_q ##1 !lock_q || edge_c)
    else $error("clock loss not reverted");
  a_no_spread: assert property (lock_q |-> !ss_en)
    else $error("spread active while locked");
  a_spread_off: assert property (!sps_s |-> !ss_en)
    else $error("spread active with input low");
  a_bias_first: assert property (st_q == bmpg_pkg::ST_BIAS && !rail_s |=> !CONV_EN)
    else $error("converter started before rail good");
  a_shutdown: assert property (!en_s ##1 !en_s |=> !HS_ON && !LS_ON && !BIAS_EN)
    else $error("not shut down");
  a_soft_hold: assert property (st_q == bmpg_pkg::ST_SOFT && en_s && tmr_q != SOFT_END
                                |=> st_q == bmpg_pkg::ST_SOFT)
    else $error("soft-start cut short");
  a_ok_drive: assert property (ev[bmpg_pkg::EV_PGF] |=> OUTPUT_OK_FLAG_OE)
    else $error("ok flag not pulled low");
  a_bias_src: assert property (BIAS_FROM_OUT |-> st_q == bmpg_pkg::ST_RUN)
    else $error("rail source moved early");
  a_duty_cap: assert property (HS_ON |-> on_cnt_q < cap_q)
    else $error("on-time over cap");
  a_hiccup_in: assert property (st_q == bmpg_pkg::ST_RUN && en_s && short_c
                                |=> st_q == bmpg_pkg::ST_HICCUP ##1 !HS_ON)
    else $error("no hiccup on short");
  a_no_hic_ss: assert property (st_q == bmpg_pkg::ST_SOFT |=> st_q != bmpg_pkg::ST_HICCUP)
    else $error("hiccup during soft-start");
  a_level_mode: assert property (!lock_q && edges_q == 2'h0 && clk_s
                                 |=> mode_q == bmpg_pkg::MD_FORCED_FIXED_FREQUENCY_MODE)
    else $error("static high not forced mode");

  c_lock: cover property (ev[bmpg_pkg::EV_LOCK]);
  c_lost: cover property (ev[bmpg_pkg::EV_LOST]);
  c_hiccup: cover property (st_q == bmpg_pkg::ST_HICCUP ##1 st_q == bmpg_pkg::ST_SOFT);
  c_ok_up: cover property ($rose(pg_q));
endmodule

/* File: verif/bmpg_ctrl_model.sv */
`timescale 1ns/1ps
module bmpg_ctrl_model
(
  // Requests from the bench
  input  wire logic en_req,
  input  wire logic lvl_req,
  input  wire logic clk_req,
  input  wire logic ss_req,
  // Open-drain ok pin
  input  wire logic ok_oe,
  output logic      ok_pin,
  // Pins toward the device
  output logic      en_pin,
  output logic      mode_pin,
  output logic      ss_pin
);
  logic ext_ck = 1'b0;

  // 400 ns clock, offset so its edges never meet the system clock's
  initial
  begin
    #7;
    forever #200 ext_ck = clk_req ? ~ext_ck : 1'b0;
  end

  // Static level or running clock; stands still when not requested
  assign mode_pin = clk_req ? ext_ck : lvl_req;
  assign ss_pin   = ss_req;
  assign en_pin   = en_req;
  // Board pull-up wins whenever the device lets go
  assign ok_pin   = ok_oe ? 1'b0 : 1'b1;
endmodule

/* File: verif/buck_mode_and_power_good_control_bench.sv */
`timescale 1ns/1ps
module buck_mode_and_power_good_control_bench;
  localparam int SOFT = 64;
  localparam int HIC  = 200;
  localparam int DMAX = int'(bmpg_pkg::PER_400K) * bmpg_pkg::DUTY_MAX_PCT / bmpg_pkg::PCT_FULL;
  localparam int PER  = int'(bmpg_pkg::PER_400K);
  localparam int DEV  = PER * bmpg_pkg::SS_DEV_PCT / bmpg_pkg::PCT_FULL;
  localparam logic [7:0] STA = bmpg_pkg::REG_STATUS;
  localparam logic [7:0] STE = bmpg_pkg::REG_STATE;

  logic        CLK_SYS = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rd_val;
  logic        RAIL_OK = 1'b0, VOUT_UV = 1'b0, VOUT_OV = 1'b0, ILIM = 1'b0, VOUT_HALF = 1'b0;
  logic        ON_END = 1'b0, LIGHT_LOAD = 1'b0, ZERO_CROSS = 1'b0;
  logic        en_req = 1'b0, lvl_req = 1'b0, clk_req = 1'b0, ss_req = 1'b0;
  logic        IRQ, BIAS_EN, BIAS_FROM_OUT, CONV_EN, HS_ON, LS_ON, OK_I, OK_O, OK_OE;
  logic        EN, MODE_CLK, SPR;
  logic [7:0]  SS_REF;
  logic [31:0] seed = 32'h57bed7d8;
  logic        rnd_on = 1'b0, hs_meas = 1'b0, hs_d = 1'b0;
  int          failures = 0, cmp_count = 0, hs_run = 0, hs_max = 0;
  int          tk_run = 0, tk_min = 255, tk_max = 0;

  bmpg_top #(.SOFT_CYC(SOFT), .HICCUP_CYC(HIC), .SS_TRI_CYC(64)) bmpg_top_inst (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .EN(EN), .MODE_CLK(MODE_CLK), .SPREAD_ENABLE_INPUT(SPR),
    .RAIL_OK(RAIL_OK), .VOUT_UV(VOUT_UV), .VOUT_OV(VOUT_OV), .ILIM(ILIM),
    .VOUT_HALF(VOUT_HALF), .ON_END(ON_END), .LIGHT_LOAD(LIGHT_LOAD),
    .ZERO_CROSS(ZERO_CROSS), .BIAS_EN(BIAS_EN), .BIAS_FROM_OUT(BIAS_FROM_OUT),
    .CONV_EN(CONV_EN), .HS_ON(HS_ON), .LS_ON(LS_ON), .SS_REF(SS_REF),
    .OUTPUT_OK_FLAG_I(OK_I), .OUTPUT_OK_FLAG_O(OK_O), .OUTPUT_OK_FLAG_OE(OK_OE));

  bmpg_ctrl_model bmpg_ctrl_model_inst (
    .en_req(en_req), .lvl_req(lvl_req), .clk_req(clk_req), .ss_req(ss_req),
    .ok_oe(OK_OE), .ok_pin(OK_I), .en_pin(EN), .mode_pin(MODE_CLK), .ss_pin(SPR));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  always #25 CLK_SYS = ~CLK_SYS;

  // Random loop signals; only these drive them, so no race with the main sequence
  always @(posedge CLK_SYS)
  begin
    seed <= xs(seed);
    ON_END <= rnd_on & seed[0];
    LIGHT_LOAD <= rnd_on & seed[1];
    ZERO_CROSS <= rnd_on & seed[2];
    hs_run <= HS_ON ? hs_run + 1 : 0;
    hs_d <= HS_ON;
    tk_run <= (HS_ON && !hs_d) ? 1 : tk_run + 1;
    if (hs_meas && hs_run > hs_max)
      hs_max <= hs_run;
    if (!hs_meas)
    begin
      tk_min <= 255;
      tk_max <= 0;
    end
    else if (HS_ON && !hs_d)
    begin
      if (tk_run < tk_min)
        tk_min <= tk_run;
      if (tk_run > tk_max)
        tk_max <= tk_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 rd_val = RDATA;
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Poll a register field; each try costs two cycles
  task automatic wait_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                         input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      rd(a);
      if ((rd_val & m) === v)
        break;
    end
    if (i == lim)
    begin
      failures++;
      $display("BAD %0t wait at %h ran out", $time, a);
      stop_test();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  initial
  begin
    step(6);
    NRST <= 1'b1;
    #1 chk(BIAS_EN, 1'b0, "rail on after reset");
    chk(OK_OE, 1'b1, "ok flag released at reset");
    chk(OK_O, 1'b0, "ok pin driven high");
    rd(bmpg_pkg::REG_MASK);
    chk(rd_val, 32'h0, "mask reset");
    rd(8'h40);
    chk(rd_val, 32'h0, "unmapped read");
    wr(STE, 32'hffffffff);
    rd(STE);
    chk(rd_val & 32'h7, 32'h0, "state written");
    wait_rd(STE, 32'h30, 32'h00, 200);
    lvl_req <= 1'b1;
    wait_rd(STE, 32'h30, 32'h10, 200);
    $display("test mode level done");
    // Start-up with the rail late
    wr(bmpg_pkg::REG_MASK, 32'h1 << bmpg_pkg::EV_SOFT);
    wr(STA, 32'h1f);
    en_req <= 1'b1;
    wait_rd(STE, 32'h7, 32'h1, 20);
    chk(CONV_EN, 1'b0, "converter before rail");
    RAIL_OK <= 1'b1;
    wait_rd(STE, 32'h7, 32'h3, 20);
    chk(BIAS_FROM_OUT, 1'b0, "rail from output in soft start");
    step(SOFT - 8);
    rd(STE);
    chk(rd_val & 32'h7, 32'h3, "soft start too short");
    chk(32'(SS_REF != 8'hff), 32'h1, "ramp at top early");
    wait_rd(STE, 32'h7, 32'h2, 10);
    chk(SS_REF, 8'hff, "ramp end");
    chk(BIAS_FROM_OUT, 1'b1, "rail source after start");
    chk(IRQ, 1'b1, "soft done irq");
    wr(STA, 32'h1 << bmpg_pkg::EV_SOFT);
    #1 chk(IRQ, 1'b0, "irq after clear");
    $display("test start-up done");
    // Forced PWM with the loop never ending the pulse
    hs_meas <= 1'b1;
    step(300);
    hs_meas <= 1'b0;
    chk(32'(hs_max), 32'(DMAX), "longest high-side pulse");
    chk(tk_min, PER, "tick spacing short unspread");
    chk(tk_max, PER, "tick spacing long unspread");
    // Spread on: tick spacing must wander inside the band
    ss_req <= 1'b1;
    step(20);
    hs_meas <= 1'b1;
    step(300);
    hs_meas <= 1'b0;
    chk(32'(tk_min >= PER - DEV && tk_max <= PER + DEV), 32'h1, "spread span");
    chk(32'(tk_max > tk_min), 32'h1, "no frequency spread");
    ss_req <= 1'b0;
    $display("test duty and spread done");
    // Output window, under then over
    for (int k = 0; k < 2; k++)
    begin
      wait_rd(STE, 32'h40, 32'h40, 1200);
      chk(OK_I, 1'b1, "ok pin high");
      rd(STE);
      chk(rd_val[8], 1'b1, "pin level high");
      wr(STA, 32'h1f);
      if (k == 0)
        VOUT_UV <= 1'b1;
      else
        VOUT_OV <= 1'b1;
      step(500);
      chk(OK_OE, 1'b0, "ok flag dropped early");
      wait_rd(STE, 32'h40, 32'h00, 400);
      chk(OK_I, 1'b0, "ok pin low");
      rd(STE);
      chk(rd_val[8], 1'b0, "pin level low");
      rd(STA);
      chk(rd_val[bmpg_pkg::EV_PGF], 1'b1, "ok fell event");
      VOUT_UV <= 1'b0;
      VOUT_OV <= 1'b0;
    end
    $display("test window done");
    // External clock with random loop traffic
    rnd_on <= 1'b1;
    lvl_req <= 1'b0;
    ss_req <= 1'b1;
    clk_req <= 1'b1;
    wait_rd(STE, 32'h38, 32'h28, 20);
    chk(rd_val[7], 1'b0, "spread while locked");
    rd(STA);
    chk(rd_val[bmpg_pkg::EV_LOCK], 1'b1, "lock event");
    clk_req <= 1'b0;
    wait_rd(STE, 32'h38, 32'h00, 30);
    chk(rd_val[7], 1'b1, "spread after fallback");
    rd(STA);
    chk(rd_val[bmpg_pkg::EV_LOST], 1'b1, "lost event");
    ss_req <= 1'b0;
    wait_rd(STE, 32'h80, 32'h00, 10);
    $display("test sync done");
    // Short circuit, hiccup, restart into soft start
    rnd_on <= 1'b0;
    ILIM <= 1'b1;
    VOUT_HALF <= 1'b1;
    wait_rd(STE, 32'h7, 32'h6, 10);
    chk(CONV_EN | HS_ON, 1'b0, "switching in hiccup");
    step(HIC - 12);
    rd(STE);
    chk(rd_val & 32'h7, 32'h6, "hiccup too short");
    wait_rd(STE, 32'h7, 32'h3, 20);
    step(20);
    rd(STE);
    chk(rd_val & 32'h7, 32'h3, "short seen in soft start");
    ILIM <= 1'b0;
    VOUT_HALF <= 1'b0;
    wait_rd(STE, 32'h7, 32'h2, 50);
    $display("test short done");
    en_req <= 1'b0;
    step(6);
    #1 chk({BIAS_EN, CONV_EN, HS_ON, LS_ON}, 4'h0, "shutdown");
    chk(OK_OE, 1'b1, "ok flag in shutdown");
    $display("test shutdown done");
    stop_test();
  end
endmodule
